/* design/sdram_arb_pkg.sv */
// Constants, types and helpers for the SDRAM queue arbiter configuration
// What this block does
// - Tx read pointer reset bit rewinds pointer
// - Tx write pointer reset bit rewinds pointer
// - Self-test enable runs test, halts traffic
// - Done flag set when self test finishes
// - Result flag zero pass, one fail
// - Fail flag cleared only by device reset
// - Wrap bit: sequential or interleaved bursts
// - Three-bit burst length, resets to 011
// - Mode-write bit pushes mode and refresh settings
// - Refresh interval scaled by eight, reset 46h
// - Arbiter serves MAC and HDLC queue transfers
// - Queue size registers at 40h and 41h
// - Receive capacity is size times 32 packets
// - Transmit capacity is size times 32 packets
// - Receive pointer reset bits rewind pointers
package sdram_arb_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] QPTR_RESET_ADDR = 8'h12;
  localparam logic [7:0] SELFTEST_ENABLE_ADDR = 8'h20;
  localparam logic [7:0] SELFTEST_RESULT_ADDR = 8'h21;
  localparam logic [7:0] MODE_BURST_ADDR = 8'h3a;
  localparam logic [7:0] MODE_LATENCY_ADDR = 8'h3b;
  localparam logic [7:0] MODE_WRITE_ADDR = 8'h3c;
  localparam logic [7:0] REFRESH_ADDR = 8'h3d;
  localparam logic [7:0] RX_QUEUE_SIZE_ADDR = 8'h40;
  localparam logic [7:0] TX_QUEUE_SIZE_ADDR = 8'h41;
  localparam logic [7:0] QUEUE_STATUS_ADDR = 8'h42;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int TX_WPTR_RST_BIT = 0;
  localparam int TX_RPTR_RST_BIT = 1;
  localparam int RX_WPTR_RST_BIT = 2;
  localparam int RX_RPTR_RST_BIT = 3;
  localparam int WRAP_TYPE_BIT = 3;
  localparam logic [2:0] BURST_LENGTH_RESET = 3'h3;
  localparam logic [2:0] CAS_LATENCY_RESET = 3'h2;
  localparam logic [7:0] REFRESH_RESET = 8'h46;
  localparam logic [7:0] RX_QUEUE_SIZE_RESET = 8'h3d;
  localparam logic [7:0] TX_QUEUE_SIZE_RESET = 8'h03;

  // ************************************************************
  // Counts and timing
  // ************************************************************
  localparam logic [12:0] PKTS_PER_STEP = 13'h0020;
  localparam int PACKET_BYTES = 2048;
  localparam int SYS_CLOCK_MHZ = 200;
  localparam int MEM_CLOCK_MHZ = 100;
  localparam int REFRESH_SCALE = 8;
  localparam logic [11:0] REFRESH_STEP_CYCLES =
    12'(REFRESH_SCALE * SYS_CLOCK_MHZ / MEM_CLOCK_MHZ);
  localparam logic [8:0] BIST_WORDS = 9'h100;
  localparam logic [15:0] BIST_SEED = 16'h5a5a;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    CMD_NOP = 3'h0,
    CMD_WRITE = 3'h1,
    CMD_READ = 3'h2,
    CMD_MODE = 3'h3,
    CMD_REFRESH = 3'h4
  } cmd_kind_t;

  typedef enum logic [4:0] {
    BIST_IDLE = 5'h01,
    BIST_WRITE = 5'h02,
    BIST_READ = 5'h04,
    BIST_WAIT = 5'h08,
    BIST_DONE = 5'h10
  } bist_state_t;

  typedef struct packed {
    cmd_kind_t kind;
    logic [13:0] addr;
    logic [15:0] wdata;
  } mem_cmd_t;

  typedef struct packed {
    logic [2:0] cas_latency;
    logic wrap_type;
    logic [2:0] burst_length;
  } mode_word_t;

  typedef struct packed {
    logic rx_push;
    logic rx_pop;
    logic tx_push;
    logic tx_pop;
  } queue_req_t;

  typedef struct packed {
    logic rx_full;
    logic rx_empty;
    logic tx_full;
    logic tx_empty;
  } queue_flags_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic phase;
    logic [12:0] idx;
  } qptr_t;

  // Test word derived from its address, used on write and compare
  function automatic logic [15:0] bist_pattern(input logic [8:0] i);
    return {i[7:0], ~i[7:0]} ^ BIST_SEED;
  endfunction

endpackage

/* design/sdram_queue_arbiter_config.sv */
// SDRAM queue arbiter with mode, refresh and self-test control
//
// Local design decision: the strobed register port.
module sdram_queue_arbiter_config (
  input wire logic clock,
  input wire logic rstn,
  input wire sdram_arb_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata_q,
  input wire sdram_arb_pkg::queue_req_t q_req,
  output sdram_arb_pkg::queue_req_t q_grant_q,
  output sdram_arb_pkg::queue_flags_t q_flags_q,
  output sdram_arb_pkg::mem_cmd_t mem_cmd_q,
  input wire logic mem_rvalid,
  input wire logic [15:0] mem_rdata,
  output sdram_arb_pkg::mode_word_t mode_applied_q,
  output logic [7:0] refresh_applied_q
);

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [12:0] capacity(input logic [7:0] size);
    return 13'(13'(size) * sdram_arb_pkg::PKTS_PER_STEP);
  endfunction

  function automatic sdram_arb_pkg::qptr_t advance(
    input sdram_arb_pkg::qptr_t p, input logic [12:0] cap);
    sdram_arb_pkg::qptr_t n;
    n = p;
    if (p.idx >= cap - 13'h0001) begin
      n.idx = '0;
      n.phase = ~p.phase;
    end else begin
      n.idx = p.idx + 13'h0001;
    end
    return n;
  endfunction

  function automatic logic is_full(input sdram_arb_pkg::qptr_t w,
                                   input sdram_arb_pkg::qptr_t r);
    return (w.idx == r.idx) && (w.phase != r.phase);
  endfunction

  function automatic logic is_empty(input sdram_arb_pkg::qptr_t w,
                                    input sdram_arb_pkg::qptr_t r);
    return w == r;
  endfunction

  function automatic logic [3:0] rr_pick(input logic [3:0] elig,
                                         input logic [1:0] start);
    logic [3:0] g;
    logic [1:0] k;
    g = '0;
    for (int i = 0; i < 4; i++) begin
      k = 2'(start + 2'(i));
      if (g == '0 && elig[k]) begin
        g[k] = 1'b1;
      end
    end
    return g;
  endfunction

  // ************************************************************
  // Registers
  // ************************************************************
  logic [3:0] qptr_rst_q;
  logic selftest_go_q;
  logic selftest_done_q;
  logic selftest_fail_q;
  logic wrap_type_q;
  logic [2:0] burst_length_q;
  logic [2:0] cas_latency_q;
  logic mode_write_strobe_q;
  logic [7:0] refresh_interval_q;
  logic [7:0] rx_queue_size_q;
  logic [7:0] tx_queue_size_q;
  logic mode_pend_q;
  logic ref_pend_q;
  logic [11:0] ref_cnt_q;
  logic [1:0] rr_q;
  sdram_arb_pkg::qptr_t rx_wptr_q, rx_rptr_q, tx_wptr_q, tx_rptr_q;
  sdram_arb_pkg::bist_state_t bist_q;
  logic [8:0] bist_idx_q;
  logic [8:0] bist_rsp_q;

  logic mode_arm;
  assign mode_arm = reg_req.wr && reg_req.addr ==
    sdram_arb_pkg::MODE_WRITE_ADDR && reg_req.wdata[0] &&
    !mode_write_strobe_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      qptr_rst_q <= '0;
      selftest_go_q <= 1'b0;
      wrap_type_q <= 1'b0;
      burst_length_q <= sdram_arb_pkg::BURST_LENGTH_RESET;
      cas_latency_q <= sdram_arb_pkg::CAS_LATENCY_RESET;
      mode_write_strobe_q <= 1'b0;
      refresh_interval_q <= sdram_arb_pkg::REFRESH_RESET;
      rx_queue_size_q <= sdram_arb_pkg::RX_QUEUE_SIZE_RESET;
      tx_queue_size_q <= sdram_arb_pkg::TX_QUEUE_SIZE_RESET;
    end else if (reg_req.wr) begin
      if (reg_req.addr == sdram_arb_pkg::QPTR_RESET_ADDR) begin
        qptr_rst_q <= reg_req.wdata[3:0];
      end else if (reg_req.addr == sdram_arb_pkg::SELFTEST_ENABLE_ADDR) begin
        selftest_go_q <= reg_req.wdata[0];
      end else if (reg_req.addr == sdram_arb_pkg::MODE_BURST_ADDR) begin
        wrap_type_q <= reg_req.wdata[sdram_arb_pkg::WRAP_TYPE_BIT];
        burst_length_q <= reg_req.wdata[2:0];
      end else if (reg_req.addr == sdram_arb_pkg::MODE_LATENCY_ADDR) begin
        // Latency other than 2 or 3 is stored as written
        cas_latency_q <= reg_req.wdata[2:0];
      end else if (reg_req.addr == sdram_arb_pkg::MODE_WRITE_ADDR) begin
        mode_write_strobe_q <= reg_req.wdata[0];
      end else if (reg_req.addr == sdram_arb_pkg::REFRESH_ADDR) begin
        refresh_interval_q <= reg_req.wdata;
      end else if (reg_req.addr == sdram_arb_pkg::RX_QUEUE_SIZE_ADDR) begin
        rx_queue_size_q <= reg_req.wdata;
      end else if (reg_req.addr == sdram_arb_pkg::TX_QUEUE_SIZE_ADDR) begin
        tx_queue_size_q <= reg_req.wdata;
      end
    end
  end

  // ************************************************************
  // Command selection
  // ************************************************************
  logic [12:0] rx_cap, tx_cap;
  logic rx_full, rx_empty, tx_full, tx_empty;
  logic [3:0] elig, pick;
  logic bist_issue, ref_issue, mode_issue;
  sdram_arb_pkg::queue_req_t grant_d;
  sdram_arb_pkg::mem_cmd_t cmd_d;

  assign rx_cap = capacity(rx_queue_size_q);
  assign tx_cap = capacity(tx_queue_size_q);
  assign rx_full = is_full(rx_wptr_q, rx_rptr_q);
  assign rx_empty = is_empty(rx_wptr_q, rx_rptr_q);
  assign tx_full = is_full(tx_wptr_q, tx_rptr_q);
  assign tx_empty = is_empty(tx_wptr_q, tx_rptr_q);

  // A pointer held in reset takes no traffic
  assign elig = {
    q_req.rx_push && !rx_full && !qptr_rst_q[sdram_arb_pkg::RX_WPTR_RST_BIT],
    q_req.rx_pop && !rx_empty && !qptr_rst_q[sdram_arb_pkg::RX_RPTR_RST_BIT],
    q_req.tx_push && !tx_full && !qptr_rst_q[sdram_arb_pkg::TX_WPTR_RST_BIT],
    q_req.tx_pop && !tx_empty && !qptr_rst_q[sdram_arb_pkg::TX_RPTR_RST_BIT]
  };
  assign pick = rr_pick(elig, rr_q);

  always_comb begin
    cmd_d = '0;
    grant_d = '0;
    bist_issue = 1'b0;
    ref_issue = 1'b0;
    mode_issue = 1'b0;
    if (mode_pend_q) begin
      mode_issue = 1'b1;
      cmd_d.kind = sdram_arb_pkg::CMD_MODE;
      cmd_d.wdata = 16'({cas_latency_q, wrap_type_q, burst_length_q});
    end else if (ref_pend_q) begin
      ref_issue = 1'b1;
      cmd_d.kind = sdram_arb_pkg::CMD_REFRESH;
    end else if (selftest_go_q) begin
      if (bist_q == sdram_arb_pkg::BIST_WRITE) begin
        bist_issue = 1'b1;
        cmd_d.kind = sdram_arb_pkg::CMD_WRITE;
        cmd_d.addr = 14'(bist_idx_q);
        cmd_d.wdata = sdram_arb_pkg::bist_pattern(bist_idx_q);
      end else if (bist_q == sdram_arb_pkg::BIST_READ) begin
        bist_issue = 1'b1;
        cmd_d.kind = sdram_arb_pkg::CMD_READ;
        cmd_d.addr = 14'(bist_idx_q);
      end
    end else begin
      // Round robin over MAC and HDLC requests
      grant_d = pick;
      if (pick[3]) begin
        cmd_d.kind = sdram_arb_pkg::CMD_WRITE;
        cmd_d.addr = 14'(rx_wptr_q.idx);
      end else if (pick[2]) begin
        cmd_d.kind = sdram_arb_pkg::CMD_READ;
        cmd_d.addr = 14'(rx_rptr_q.idx);
      end else if (pick[1]) begin
        // Transmit queue sits above the receive queue
        cmd_d.kind = sdram_arb_pkg::CMD_WRITE;
        cmd_d.addr = 14'(14'(rx_cap) + 14'(tx_wptr_q.idx));
      end else if (pick[0]) begin
        cmd_d.kind = sdram_arb_pkg::CMD_READ;
        cmd_d.addr = 14'(14'(rx_cap) + 14'(tx_rptr_q.idx));
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mem_cmd_q <= '0;
      q_grant_q <= '0;
      q_flags_q <= '0;
      rr_q <= '0;
    end else begin
      mem_cmd_q <= cmd_d;
      q_grant_q <= grant_d;
      q_flags_q <= {rx_full, rx_empty, tx_full, tx_empty};
      for (int i = 0; i < 4; i++) begin
        if (grant_d[i]) begin
          rr_q <= 2'(i + 1);
        end
      end
    end
  end

  // ************************************************************
  // Queue pointers
  // ************************************************************
  // Reset bits are levels and hold the pointer
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rx_wptr_q <= '0;
      rx_rptr_q <= '0;
      tx_wptr_q <= '0;
      tx_rptr_q <= '0;
    end else begin
      if (qptr_rst_q[sdram_arb_pkg::RX_WPTR_RST_BIT]) begin
        rx_wptr_q <= '0;
      end else if (grant_d.rx_push) begin
        rx_wptr_q <= advance(rx_wptr_q, rx_cap);
      end
      if (qptr_rst_q[sdram_arb_pkg::RX_RPTR_RST_BIT]) begin
        rx_rptr_q <= '0;
      end else if (grant_d.rx_pop) begin
        rx_rptr_q <= advance(rx_rptr_q, rx_cap);
      end
      if (qptr_rst_q[sdram_arb_pkg::TX_WPTR_RST_BIT]) begin
        tx_wptr_q <= '0;
      end else if (grant_d.tx_push) begin
        tx_wptr_q <= advance(tx_wptr_q, tx_cap);
      end
      if (qptr_rst_q[sdram_arb_pkg::TX_RPTR_RST_BIT]) begin
        tx_rptr_q <= '0;
      end else if (grant_d.tx_pop) begin
        tx_rptr_q <= advance(tx_rptr_q, tx_cap);
      end
    end
  end

  // ************************************************************
  // Mode write and refresh
  // ************************************************************
  logic [11:0] ref_target;
  logic ref_tick;
  assign ref_target = 12'(12'(refresh_applied_q) *
                          sdram_arb_pkg::REFRESH_STEP_CYCLES);
  // A shrunk interval must not leave the counter running past its end
  assign ref_tick = (ref_target != '0) &&
                    (ref_cnt_q >= ref_target - 12'h001);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mode_pend_q <= 1'b0;
      mode_applied_q <= {sdram_arb_pkg::CAS_LATENCY_RESET, 1'b0,
                         sdram_arb_pkg::BURST_LENGTH_RESET};
      refresh_applied_q <= sdram_arb_pkg::REFRESH_RESET;
    end else begin
      // Only a zero-to-one write arms a new push
      if (mode_arm) begin
        mode_pend_q <= 1'b1;
      end else if (mode_issue) begin
        mode_pend_q <= 1'b0;
      end
      // Latency, wrap type, burst length and refresh interval applied
      if (mode_issue) begin
        mode_applied_q <= {cas_latency_q, wrap_type_q, burst_length_q};
        refresh_applied_q <= refresh_interval_q;
      end
    end
  end

  // Refresh period is interval times eight memory clocks
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ref_cnt_q <= '0;
      ref_pend_q <= 1'b0;
    end else begin
      ref_cnt_q <= ref_tick ? '0 : ref_cnt_q + 12'h001;
      if (ref_tick) begin
        ref_pend_q <= 1'b1;
      end else if (ref_issue) begin
        ref_pend_q <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Memory self test
  // ************************************************************
  logic bist_checking;
  assign bist_checking = (bist_q == sdram_arb_pkg::BIST_READ) ||
                         (bist_q == sdram_arb_pkg::BIST_WAIT);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bist_q <= sdram_arb_pkg::BIST_IDLE;
      bist_idx_q <= '0;
      bist_rsp_q <= '0;
      selftest_done_q <= 1'b0;
    end else begin
      if (bist_checking && mem_rvalid) begin
        bist_rsp_q <= bist_rsp_q + 9'h001;
      end
      case (bist_q)
        sdram_arb_pkg::BIST_IDLE: begin
          if (selftest_go_q) begin
            bist_q <= sdram_arb_pkg::BIST_WRITE;
            bist_idx_q <= '0;
            bist_rsp_q <= '0;
          end
        end
        sdram_arb_pkg::BIST_WRITE: begin
          if (!selftest_go_q) begin
            bist_q <= sdram_arb_pkg::BIST_IDLE;
          end else if (bist_issue) begin
            bist_idx_q <= bist_idx_q + 9'h001;
            if (bist_idx_q == sdram_arb_pkg::BIST_WORDS - 9'h001) begin
              bist_q <= sdram_arb_pkg::BIST_READ;
              bist_idx_q <= '0;
            end
          end
        end
        sdram_arb_pkg::BIST_READ: begin
          if (!selftest_go_q) begin
            bist_q <= sdram_arb_pkg::BIST_IDLE;
          end else if (bist_issue) begin
            bist_idx_q <= bist_idx_q + 9'h001;
            if (bist_idx_q == sdram_arb_pkg::BIST_WORDS - 9'h001) begin
              bist_q <= sdram_arb_pkg::BIST_WAIT;
            end
          end
        end
        sdram_arb_pkg::BIST_WAIT: begin
          if (!selftest_go_q) begin
            bist_q <= sdram_arb_pkg::BIST_IDLE;
          end else if (bist_rsp_q == sdram_arb_pkg::BIST_WORDS) begin
            // Done once every read has returned
            bist_q <= sdram_arb_pkg::BIST_DONE;
            selftest_done_q <= 1'b1;
          end
        end
        // Done state is left only by reset
        default: begin
          bist_q <= sdram_arb_pkg::BIST_DONE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      selftest_fail_q <= 1'b0;
    end else if (bist_checking && mem_rvalid &&
                 mem_rdata != sdram_arb_pkg::bist_pattern(bist_rsp_q)) begin
      selftest_fail_q <= 1'b1;
    end
  end

  // ************************************************************
  // Register read port
  // ************************************************************
  logic [7:0] rdata_d;
  always_comb begin
    rdata_d = '0;
    if (reg_req.addr == sdram_arb_pkg::QPTR_RESET_ADDR) begin
      rdata_d = {4'h0, qptr_rst_q};
    end else if (reg_req.addr == sdram_arb_pkg::SELFTEST_ENABLE_ADDR) begin
      rdata_d = {7'h00, selftest_go_q};
    end else if (reg_req.addr == sdram_arb_pkg::SELFTEST_RESULT_ADDR) begin
      rdata_d = {6'h00, selftest_done_q, selftest_fail_q};
    end else if (reg_req.addr == sdram_arb_pkg::MODE_BURST_ADDR) begin
      rdata_d = {4'h0, wrap_type_q, burst_length_q};
    end else if (reg_req.addr == sdram_arb_pkg::MODE_LATENCY_ADDR) begin
      rdata_d = {5'h00, cas_latency_q};
    end else if (reg_req.addr == sdram_arb_pkg::MODE_WRITE_ADDR) begin
      rdata_d = {7'h00, mode_write_strobe_q};
    end else if (reg_req.addr == sdram_arb_pkg::REFRESH_ADDR) begin
      rdata_d = refresh_interval_q;
    end else if (reg_req.addr == sdram_arb_pkg::RX_QUEUE_SIZE_ADDR) begin
      // Arbiter space opens with the size registers
      rdata_d = rx_queue_size_q;
    end else if (reg_req.addr == sdram_arb_pkg::TX_QUEUE_SIZE_ADDR) begin
      rdata_d = tx_queue_size_q;
    end else if (reg_req.addr == sdram_arb_pkg::QUEUE_STATUS_ADDR) begin
      rdata_d = {4'h0, rx_full, rx_empty, tx_full, tx_empty};
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_q <= '0;
    end else begin
      reg_rdata_q <= reg_req.rd ? rdata_d : 8'h00;
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  sequence s_mode_armed;
    mode_arm ##1 mode_pend_q;
  endsequence

  sequence s_mode_sent;
    mem_cmd_q.kind == sdram_arb_pkg::CMD_MODE ##1
      mode_applied_q == {$past(cas_latency_q, 2), $past(wrap_type_q, 2),
                         $past(burst_length_q, 2)};
  endsequence

  a_tx_rptr_reset: assert property (
    qptr_rst_q[1] |=> tx_rptr_q == '0)
    else $error("tx read pointer not rewound");
  a_tx_wptr_reset: assert property (
    qptr_rst_q[0] |=> tx_wptr_q == '0)
    else $error("tx write pointer not rewound");
  a_rx_wptr_reset: assert property (
    qptr_rst_q[2] |=> rx_wptr_q == '0)
    else $error("rx write pointer not rewound");
  a_rx_rptr_reset: assert property (
    qptr_rst_q[3] |=> rx_rptr_q == '0)
    else $error("rx read pointer not rewound");
  a_selftest_halts: assert property (
    selftest_go_q |=> q_grant_q == '0)
    else $error("traffic granted during self test");
  a_done_all_read: assert property (
    $rose(selftest_done_q) |-> bist_rsp_q == sdram_arb_pkg::BIST_WORDS)
    else $error("done before all reads returned");
  a_fail_from_read: assert property (
    $rose(selftest_fail_q) |-> $past(mem_rvalid) && $past(bist_checking))
    else $error("fail flag without a compared read");
  a_fail_sticky: assert property (
    selftest_fail_q |=> selftest_fail_q)
    else $error("fail flag cleared without reset");
  a_mode_push: assert property (
    s_mode_armed |=> s_mode_sent)
    else $error("mode write not pushed to memory");
  a_refresh_tick: assert property (
    ref_tick |=> ref_cnt_q == '0 && ref_pend_q)
    else $error("refresh period not honoured");
  a_full_blocks: assert property (
    rx_full |=> !q_grant_q.rx_push)
    else $error("push granted into full rx queue");
  a_size_read: assert property (
    reg_req.rd && reg_req.addr == sdram_arb_pkg::TX_QUEUE_SIZE_ADDR
      |=> reg_rdata_q == $past(tx_queue_size_q))
    else $error("tx size read back wrong");

endmodule

/* testbench/sdram_model.sv */
// SDRAM stand-in that stores writes and answers reads in order
module sdram_model (
  input wire logic clock,
  input wire logic rstn,
  input wire sdram_arb_pkg::mem_cmd_t cmd,
  input wire logic stall,
  input wire logic corrupt,
  output logic mem_rvalid,
  output logic [15:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [logic [13:0]];
  logic [15:0] pend [$];
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pend.delete();
      mem_rvalid <= 1'b0;
      mem_rdata <= 16'h0000;
    end else begin
      if (cmd.kind == sdram_arb_pkg::CMD_WRITE)
        mem[cmd.addr] = cmd.wdata;
      if (cmd.kind == sdram_arb_pkg::CMD_READ)
        pend.push_back(mem.exists(cmd.addr) ?
          mem[cmd.addr] ^ {15'h0000, corrupt} : 16'hc3a5);
      mem_rvalid <= 1'b0;
      // Idle data toggles so a stale sample never matches
      mem_rdata <= ~mem_rdata;
      if (pend.size() > 0 && !stall) begin
        mem_rvalid <= 1'b1;
        mem_rdata <= pend.pop_front();
      end
    end
  end
endmodule

/* testbench/test_sdram_queue_arbiter_config.sv */
// Self-checking bench for the SDRAM queue arbiter configuration
module test_sdram_queue_arbiter_config;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, rstn = 1'b0, stall = 1'b0, corrupt = 1'b0;
  logic mem_rvalid;
  logic [15:0] mem_rdata;
  logic [7:0] reg_rdata_q, refresh_applied_q;
  sdram_arb_pkg::reg_req_t reg_req = '0;
  sdram_arb_pkg::queue_req_t q_req = '0;
  sdram_arb_pkg::queue_req_t q_grant_q;
  sdram_arb_pkg::queue_flags_t q_flags_q;
  sdram_arb_pkg::mem_cmd_t mem_cmd_q;
  sdram_arb_pkg::mode_word_t mode_applied_q;
  logic [31:0] seed = 32'd60282;
  logic [7:0] regs [0:255];
  logic [7:0] msk [0:255];
  logic [7:0] addrs [11] = '{8'h12, 8'h20, 8'h21, 8'h3a, 8'h3b, 8'h3c,
    8'h3d, 8'h40, 8'h41, 8'h55, 8'h42};
  logic [7:0] masks [11] = '{8'h0f, 8'h01, 8'h00, 8'h0f, 8'h07, 8'h01,
    8'hff, 8'hff, 8'hff, 8'h00, 8'h00};
  int mismatches = 0, comparisons = 0, cycles = 0, grants = 0;
  int modes = 0, rlast = 0, rgap = 0;

  sdram_queue_arbiter_config uut (.clock(clock), .rstn(rstn),
    .reg_req(reg_req), .reg_rdata_q(reg_rdata_q), .q_req(q_req),
    .q_grant_q(q_grant_q), .q_flags_q(q_flags_q), .mem_cmd_q(mem_cmd_q),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
    .mode_applied_q(mode_applied_q), .refresh_applied_q(refresh_applied_q));
  sdram_model sdram (.clock(clock), .rstn(rstn), .cmd(mem_cmd_q),
    .stall(stall), .corrupt(corrupt), .mem_rvalid(mem_rvalid),
    .mem_rdata(mem_rdata));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  always #2.5 clock = ~clock;

  always @(posedge clock) begin
    seed <= xs(seed);
    stall <= seed[7];
    cycles <= cycles + 1;
    if (q_grant_q !== 4'h0)
      grants <= grants + 1;
    if (mem_cmd_q.kind === sdram_arb_pkg::CMD_MODE)
      modes <= modes + 1;
    if (mem_cmd_q.kind === sdram_arb_pkg::CMD_REFRESH) begin
      rgap <= cycles - rlast;
      rlast <= cycles;
    end
    if (cycles == 40000) begin
      mismatches = mismatches + 1;
      conclude();
    end
  end

  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic do_reset();
    rstn <= 1'b0;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    foreach (regs[i]) regs[i] = 8'h00;
    regs[8'h3a] = 8'h03;
    regs[8'h3b] = 8'h02;
    regs[8'h3d] = 8'h46;
    regs[8'h40] = 8'h3d;
    regs[8'h41] = 8'h03;
    // Both queues empty after reset
    regs[8'h42] = 8'h05;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_req <= {1'b1, 1'b0, a, d};
    if (msk[a] != 8'h00)
      regs[a] = d & msk[a];
    @(posedge clock);
    reg_req <= '0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    reg_req <= {1'b0, 1'b1, a, 8'h00};
    @(posedge clock);
    reg_req <= '0;
    #1 check("reg_rdata_q", reg_rdata_q, regs[a]);
  endtask

  // Holds a request for n + 20 cycles, checking every grant and the grant count
  task automatic run(input logic [3:0] req, input logic [2:0] kind,
    input int b, input int n);
    int k;
    k = 0;
    @(posedge clock);
    q_req <= req;
    repeat (n + 20) begin
      @(posedge clock);
      #1 if (q_grant_q !== 4'h0) begin
        check("grant", {q_grant_q, mem_cmd_q.kind, mem_cmd_q.addr},
          {req, kind, 14'(b + k)});
        k++;
      end
    end
    @(posedge clock);
    q_req <= '0;
    check("grants", k, n);
  endtask

  task automatic qtest(input logic rx);
    logic [3:0] p, q;
    p = rx ? 4'h8 : 4'h2;
    q = p >> 1;
    run(p, 3'h1, rx ? 0 : 32, 32);
    run(q, 3'h2, rx ? 0 : 32, 32);
    wr(8'h12, {4'h0, p});
    wr(8'h12, 8'h00);
    #1 check("q_flags_q", q_flags_q & (p | q), p);
    wr(8'h12, {4'h0, q});
    wr(8'h12, 8'h00);
    #1 check("q_flags_q", q_flags_q & (p | q), q);
  endtask

  initial begin
    logic [2:0] b, c;
    logic w;
    logic [7:0] r;
    int g, m;
    foreach (addrs[i]) msk[addrs[i]] = masks[i];
    do_reset();
    #1 check("applied", {mode_applied_q, refresh_applied_q},
      {3'h2, 1'b0, 3'h3, 8'h46});
    foreach (addrs[i]) rd(addrs[i]);
    // Latency stays legal in the all-ones pass
    foreach (addrs[i]) wr(addrs[i], addrs[i] == 8'h3b ? 8'h03 : 8'hff);
    foreach (addrs[i]) rd(addrs[i]);
    do_reset();
    repeat (2) begin
      b = seed[2:0];
      w = seed[3];
      // Latency kept at two or three
      c = seed[4] ? 3'h3 : 3'h2;
      r = {2'b00, seed[10:5]} + 8'h01;
      wr(8'h3a, {4'h0, w, b});
      wr(8'h3b, {5'h00, c});
      wr(8'h3d, r);
      m = modes;
      wr(8'h3c, 8'h00);
      wr(8'h3c, 8'h01);
      @(posedge clock);
      #1 check("mode", {mem_cmd_q.kind, mem_cmd_q.wdata},
        {3'h3, 9'h000, c, w, b});
      check("applied", {mode_applied_q, refresh_applied_q},
        {c, w, b, r});
      wr(8'h3c, 8'h01);
      repeat (r * 32 + 1200) @(posedge clock);
      check("modes", modes, m + 1);
      check("rgap", rgap, r * 16);
    end
    wr(8'h40, 8'h01);
    wr(8'h41, 8'h01);
    qtest(1'b1);
    qtest(1'b0);
    for (int f = 0; f < 2; f++) begin
      do_reset();
      corrupt <= f[0];
      wr(8'h20, 8'h01);
      q_req <= 4'h8;
      g = grants;
      repeat (1500) @(posedge clock);
      check("grants", grants, g);
      // No traffic while the self-test enable stays set
      q_req <= '0;
      regs[8'h21] = {6'h00, 1'b1, f[0]};
      wr(8'h21, 8'h00);
      rd(8'h21);
      wr(8'h20, 8'h00);
      rd(8'h21);
    end
    do_reset();
    rd(8'h21);
    conclude();
  end
endmodule
